/* File: sfsp_pkg.sv */
// Shared constants for the sequential program command engine
package sfsp_pkg;
	localparam logic [7:0] SFSP_OP_WREN = 8'h06;
	localparam logic [7:0] SFSP_OP_WRDI = 8'h04;
	localparam logic [7:0] SFSP_OP_SEQ_A = 8'hAD;
	localparam logic [7:0] SFSP_OP_SEQ_B = 8'hAF;
	localparam logic [7:0] SFSP_OP_DUAL_PP = 8'hA2;
	localparam logic [7:0] SFSP_OP_WRAP = 8'h77;
	localparam logic [7:0] SFSP_OP_PARAM = 8'h5A;
	localparam logic [23:0] SFSP_LAST_ADDR = 24'h0F_FFFF;
	localparam int SFSP_BLK64_LSB = 16;
	localparam logic [8:0] SFSP_PAGE_BYTES = 9'h100;
	localparam int SFSP_ADDR_BITS = 24;
	localparam logic [5:0] SFSP_ADDR_END = 6'h20;
	localparam logic [5:0] SFSP_OP_END = 6'h08;
	// Byte program time in ns and its cycle count at 100 MHz (longest: round down)
	localparam int SFSP_BYTE_PROGRAM_TIME_NS = 20000;
	localparam int SFSP_CLK_PERIOD_NS = 10;
	localparam int SFSP_BP_CYC_RAW = SFSP_BYTE_PROGRAM_TIME_NS / SFSP_CLK_PERIOD_NS;
	localparam int SFSP_BP_CYC = (SFSP_BP_CYC_RAW < 1) ? 1 : SFSP_BP_CYC_RAW;
	typedef enum logic [3:0] {
		SFSP_IDLE = 4'b0001,
		SFSP_PROG = 4'b0010,
		SFSP_CHECK = 4'b0100,
		SFSP_EXIT = 4'b1000
	} sfsp_state_t;
endpackage

/* File: sfsp_flash_seq_prog.sv */
// Serial flash sequential and dual program command engine
//
// Operation
// - Several bytes in one program cycle: only the last byte is kept.
// - Each byte programs by internal timer lasting byte program time; dual program runs one such timer for its whole byte count.
// - Early or misaligned select release aborts, no program, clears write enable latch.
// - Start address protected: no program, idle at release, clear latch.
// - No skipping protected blocks; exit after last unprotected byte, clear latch.
// - No address wrap; after last location exit mode and clear latch.
// - Address entering erase-suspended 64 kB block exits the mode.
// - Write enable latch cleared during mode exits mode at once.
// - Failed byte program sets erase error and program error flags.
// - Burst-with-wrap and parameter read refused while mode is active.
// - Dual program opcode accepted, one to 256 bytes programmed.
// - Dual data phase moves two bits per serial clock.
// - Dual pair: high bit on output pin, low on input pin, 7/6 first.
// - Address takes 24 clocks on input pin, MSB first.
`timescale 1ns/10ps
module sfsp_flash_seq_prog
	import sfsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	input wire logic so_i,
	input wire logic [15:0] protect_map_i,
	input wire logic suspend_valid_i,
	input wire logic [3:0] suspend_blk_i,
	input wire logic prog_fail_i,
	output logic so_o,
	output logic so_oe_n_o,
	output logic write_enable_latch_o,
	output logic seq_mode_o,
	output logic busy_o,
	output logic erase_error_flag_o,
	output logic program_error_flag_o,
	output logic refused_o,
	output logic prog_req_o,
	output logic [23:0] prog_addr_o,
	output logic [7:0] prog_data_o,
	output logic [8:0] dual_count_o
);

// ----------------------------------------
// Link side: runs on the host serial clock
// ----------------------------------------
// Frame results are held stable and flagged by a toggle; the core samples
// them only after the toggle has crossed, so the words never change in flight.
logic [7:0] l_op;
logic [7:0] l_sh;
logic [23:0] l_addr;
logic [7:0] l_data;
logic [5:0] l_hdr;
logic [11:0] l_bits;
logic l_dual;
logic l_cmd_tgl;
logic [7:0] l_cmd_op;
logic [7:0] l_sh_nx;
logic [1:0] l_pair;

assign l_pair = {so_i, si_i};
assign l_dual = (l_op == SFSP_OP_DUAL_PP) && (l_hdr == SFSP_ADDR_END);
always_comb begin
	if (l_dual) begin
		l_sh_nx = {l_sh[5:0], l_pair};
	end else begin
		l_sh_nx = {l_sh[6:0], si_i};
	end
end

// Counters restart when select is high; no link edge is relied on outside a frame
always_ff @(posedge sclk_i or posedge cs_n_i) begin
	if (cs_n_i) begin
		l_hdr <= 6'h00;
		l_bits <= 12'h000;
		l_sh <= 8'h00;
	end else begin
		l_sh <= l_sh_nx;
		if (l_hdr != SFSP_ADDR_END) begin
			l_hdr <= l_hdr + 6'h01;
		end else begin
			l_bits <= l_bits + (l_dual ? 12'h002 : 12'h001);
		end
	end
end

always_ff @(posedge sclk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		l_op <= 8'h00;
		l_addr <= 24'h00_0000;
		l_data <= 8'h00;
		l_cmd_tgl <= 1'b0;
		l_cmd_op <= 8'h00;
	end else if (!cs_n_i) begin
		if (l_hdr < SFSP_OP_END) begin
			l_op <= {l_op[6:0], si_i};
			if (l_hdr == SFSP_OP_END - 6'h01) begin
				l_cmd_op <= {l_op[6:0], si_i};
				l_cmd_tgl <= ~l_cmd_tgl;
			end
		end else if (l_hdr < SFSP_ADDR_END) begin
			l_addr <= {l_addr[22:0], si_i};
		end else if ((l_dual && l_bits[2:0] == 3'h6) || (!l_dual && l_bits[2:0] == 3'h7)) begin
			l_data <= l_sh_nx;
		end
	end
end

// --------------------------
// Core side: synchronisers
// --------------------------
logic [1:0] tgl_sync;
logic tgl_d;

always_ff @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		tgl_sync <= 2'b00;
		tgl_d <= 1'b0;
	end else if (clk_en_i) begin
		tgl_sync <= {tgl_sync[0], l_cmd_tgl};
		tgl_d <= tgl_sync[1];
	end
end

logic op_seen;
assign op_seen = tgl_sync[1] != tgl_d;

// --------------------------
// Core state
// --------------------------
typedef struct packed {
	sfsp_state_t st;
	logic write_enable_latch;
	logic seq;
	logic ee;
	logic pe;
	logic refused;
	logic req;
	logic [23:0] addr;
	logic [7:0] data;
	logic [8:0] dcount;
	logic [31:0] timer;
	logic [7:0] op;
	logic so_oe_n;
	logic busy;
} sfsp_core_t;

sfsp_core_t cur;
sfsp_core_t next_cur;

// Stable link words read only after a crossed event
logic frame_ok;
logic [23:0] next_addr_inc;
logic blk_prot;
logic blk_susp;

assign next_addr_inc = cur.addr + 24'h00_0001;
assign blk_prot = protect_map_i[next_addr_inc[SFSP_BLK64_LSB +: 4]];
assign blk_susp = suspend_valid_i && (suspend_blk_i == next_addr_inc[SFSP_BLK64_LSB +: 4]);

// Frame completeness recorded in the link domain at select release
logic l_ok;
logic [7:0] l_fin_data;
logic [23:0] l_fin_addr;
logic [8:0] l_fin_cnt;
logic l_fin_tgl;
logic l_fin_has_op;
logic l_fin_aligned;
logic l_fin_cont;
logic [7:0] l_fin_last;
always_ff @(posedge cs_n_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		l_ok <= 1'b0;
		l_fin_data <= 8'h00;
		l_fin_addr <= 24'h00_0000;
		l_fin_cnt <= 9'h000;
		l_fin_tgl <= 1'b0;
		l_fin_has_op <= 1'b0;
		l_fin_aligned <= 1'b0;
		l_fin_cont <= 1'b0;
		l_fin_last <= 8'h00;
	end else begin
		l_ok <= (l_hdr == SFSP_ADDR_END) && (l_bits != 12'h000) && (l_bits[2:0] == 3'h0);
		l_fin_data <= l_data;
		l_fin_addr <= l_addr;
		l_fin_cnt <= (l_bits[11:3] > SFSP_PAGE_BYTES) ? SFSP_PAGE_BYTES : l_bits[11:3];
		l_fin_tgl <= ~l_fin_tgl;
		l_fin_has_op <= l_hdr >= SFSP_OP_END;
		l_fin_aligned <= (l_hdr[2:0] == 3'h0) && (l_bits[2:0] == 3'h0);
		l_fin_cont <= l_hdr > SFSP_OP_END;
		l_fin_last <= l_sh;
	end
end
logic [1:0] fin_sync;
logic fin_d;
always_ff @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		fin_sync <= 2'b00;
		fin_d <= 1'b0;
	end else if (clk_en_i) begin
		fin_sync <= {fin_sync[0], l_fin_tgl};
		fin_d <= fin_sync[1];
	end
end
logic fin_seen;
assign fin_seen = fin_sync[1] != fin_d;
assign frame_ok = l_ok;

always_comb begin
	next_cur = cur;
	next_cur.req = 1'b0;
	next_cur.refused = 1'b0;
	if (op_seen) begin
		next_cur.op = l_cmd_op;
		if (cur.seq && (l_cmd_op == SFSP_OP_WRAP || l_cmd_op == SFSP_OP_PARAM)) begin
			next_cur.refused = 1'b1;
		end
		if (l_cmd_op == SFSP_OP_DUAL_PP) begin
			next_cur.so_oe_n = 1'b1; // SO becomes an input for paired data
		end
	end
	case (cur.st)
		SFSP_IDLE: begin
			if (fin_seen) begin
				next_cur.so_oe_n = 1'b1;
				if (!l_fin_has_op || (cur.seq && !l_fin_aligned)) begin
					// Cut cycle in the mode aborts; stale opcode is never applied again
					if (cur.seq) begin
						next_cur.write_enable_latch = 1'b0;
						next_cur.seq = 1'b0;
					end
				end else if (cur.seq && (cur.op == SFSP_OP_SEQ_A || cur.op == SFSP_OP_SEQ_B)) begin
					if (l_fin_cont) begin
						// Later cycles carry opcode and data only; the address follows on
						next_cur.data = l_fin_last;
						next_cur.timer = 32'(SFSP_BP_CYC);
						next_cur.req = 1'b1;
						next_cur.st = SFSP_PROG;
					end else begin
						next_cur.write_enable_latch = 1'b0;
						next_cur.seq = 1'b0;
					end
				end else if (cur.op == SFSP_OP_WREN) begin
					next_cur.write_enable_latch = 1'b1;
				end else if (cur.op == SFSP_OP_WRDI) begin
					next_cur.write_enable_latch = 1'b0;
				end else if (cur.op == SFSP_OP_SEQ_A || cur.op == SFSP_OP_SEQ_B) begin
					if (!cur.write_enable_latch) begin
						next_cur.seq = 1'b0;
					end else if (!frame_ok) begin
						next_cur.write_enable_latch = 1'b0;
						next_cur.seq = 1'b0;
					end else if (protect_map_i[l_fin_addr[SFSP_BLK64_LSB +: 4]]) begin
						next_cur.write_enable_latch = 1'b0;
						next_cur.seq = 1'b0;
					end else begin
						next_cur.seq = 1'b1;
						next_cur.addr = l_fin_addr;
						next_cur.data = l_fin_data;
						next_cur.dcount = 9'h001;
						next_cur.timer = 32'(SFSP_BP_CYC);
						next_cur.req = 1'b1;
						next_cur.st = SFSP_PROG;
					end
				end else if (cur.op == SFSP_OP_DUAL_PP && cur.write_enable_latch) begin
					if (!frame_ok || protect_map_i[l_fin_addr[SFSP_BLK64_LSB +: 4]]) begin
						next_cur.write_enable_latch = 1'b0;
					end else begin
						next_cur.addr = l_fin_addr;
						next_cur.data = l_fin_data;
						next_cur.dcount = l_fin_cnt;
						next_cur.timer = 32'(SFSP_BP_CYC);
						next_cur.req = 1'b1;
						next_cur.st = SFSP_PROG;
					end
				end
			end
		end
		SFSP_PROG: begin
			if (cur.timer > 32'h0000_0001) begin
				next_cur.timer = cur.timer - 32'h0000_0001;
			end else begin
				next_cur.st = SFSP_CHECK;
			end
		end
		SFSP_CHECK: begin
			if (prog_fail_i) begin
				next_cur.ee = 1'b1;
				next_cur.pe = 1'b1;
			end
			next_cur.st = SFSP_IDLE;
			if (cur.seq) begin
				next_cur.addr = next_addr_inc;
				if (cur.addr == SFSP_LAST_ADDR || blk_prot) begin
					next_cur.st = SFSP_EXIT;
				end else if (blk_susp) begin
					next_cur.seq = 1'b0;
				end
			end else begin
				next_cur.write_enable_latch = 1'b0;
			end
		end
		SFSP_EXIT: begin
			next_cur.seq = 1'b0;
			next_cur.write_enable_latch = 1'b0;
			next_cur.st = SFSP_IDLE;
		end
		default: begin
			next_cur.st = SFSP_IDLE;
		end
	endcase
	if (cur.seq && !next_cur.write_enable_latch) begin
		next_cur.seq = 1'b0;
	end
	next_cur.busy = (next_cur.st != SFSP_IDLE);
end

always_ff @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		cur <= '{st: SFSP_IDLE, so_oe_n: 1'b1, default: '0};
	end else if (clk_en_i) begin
		cur <= next_cur;
	end
end

// --------------------------
// Outputs
// --------------------------
// Read-back on the output pin is outside this block; pin held low and undriven.
assign so_o = 1'b0;
assign so_oe_n_o = cur.so_oe_n;
assign write_enable_latch_o = cur.write_enable_latch;
assign seq_mode_o = cur.seq;
assign busy_o = cur.busy;
assign erase_error_flag_o = cur.ee;
assign program_error_flag_o = cur.pe;
assign refused_o = cur.refused;
assign prog_req_o = cur.req;
assign prog_addr_o = cur.addr;
assign prog_data_o = cur.data;
assign dual_count_o = cur.dcount;

endmodule

/* File: sfsp_flash_seq_prog_monitor.sv */
// Port checks for the sequential program engine
`timescale 1ns/10ps
module sfsp_flash_seq_prog_monitor
	import sfsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic write_enable_latch_o,
	input wire logic seq_mode_o,
	input wire logic busy_o,
	input wire logic erase_error_flag_o,
	input wire logic program_error_flag_o,
	input wire logic refused_o,
	input wire logic prog_req_o,
	input wire logic [23:0] prog_addr_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// Length of the current busy run, checked when busy drops
	logic [11:0] busy_run;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_run <= 12'h000;
		end else begin
			busy_run <= busy_o ? busy_run + 12'h001 : 12'h000;
		end
	end
	sequence s_launch;
		prog_req_o ##1 (busy_o && !prog_req_o);
	endsequence
	sequence s_left;
		!seq_mode_o && !write_enable_latch_o;
	endsequence
	sequence s_last_done;
		(busy_o && prog_addr_o == SFSP_LAST_ADDR) ##1 (prog_addr_o != SFSP_LAST_ADDR);
	endsequence
	a_req_launch: assert property (prog_req_o |-> s_launch) else $error("request did not start busy");
	a_busy_len: assert property ($fell(busy_o) |-> busy_run inside {[SFSP_BP_CYC:SFSP_BP_CYC + 2]})
		else $error("busy length wrong");
	a_req_wel: assert property (prog_req_o |-> $past(write_enable_latch_o)) else $error("program without latch");
	a_wel_mode: assert property (seq_mode_o && !write_enable_latch_o |=> !seq_mode_o) else $error("mode kept");
	a_last_exit: assert property (s_last_done |-> ##[0:4] s_left)
		else $error("no exit after last location");
	a_refuse_mode: assert property (refused_o |-> $past(seq_mode_o) ##1 !refused_o)
		else $error("bad refusal");
	a_flag_pair: assert property (erase_error_flag_o == program_error_flag_o) else $error("flags differ");
	a_flag_hold: assert property (program_error_flag_o |=> program_error_flag_o) else $error("flag lost");
endmodule
bind sfsp_flash_seq_prog sfsp_flash_seq_prog_monitor u_mon (.clk_i(clk_i), .arst_n_i(arst_n_i),
	.write_enable_latch_o(write_enable_latch_o), .seq_mode_o(seq_mode_o), .busy_o(busy_o),
	.erase_error_flag_o(erase_error_flag_o), .program_error_flag_o(program_error_flag_o),
	.refused_o(refused_o), .prog_req_o(prog_req_o), .prog_addr_o(prog_addr_o));

/* File: sfsp_host_model.sv */
// Serial host model for the flash command pins
`timescale 1ns/10ps
module sfsp_host_model (
	output logic sclk_o,
	output logic cs_n_o,
	output logic si_o,
	output logic so_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
		so_o = 1'b1;
	end
	// Mode 0, clock stands low between frames; lines flip once released
	task automatic frame(input logic [47:0] w, input int n, input bit dual);
		int i;
		i = 0;
		cs_n_o = 1'b0;
		#7.5;
		while (i < n) begin
			if (dual && i >= 32) begin
				so_o = w[47 - i];
				si_o = w[46 - i];
				i = i + 2;
			end else begin
				si_o = w[47 - i];
				i = i + 1;
			end
			#7.5 sclk_o = 1'b1;
			#7.5 sclk_o = 1'b0;
		end
		#7.5 cs_n_o = 1'b1;
		si_o = ~si_o;
		so_o = ~so_o;
		#60;
	endtask
endmodule

/* File: sfsp_flash_seq_prog_tb_top.sv */
// Self-checking bench for the sequential program engine
`timescale 1ns/10ps
module sfsp_flash_seq_prog_tb_top;
	import sfsp_pkg::*;
	typedef struct {logic [15:0] p; logic sv; logic [23:0] a;} sfsp_exit_t;
	logic clk_i, arst_n_i, sclk, cs_n, si, so_h, susp_v, fail, so_o, so_oe_n_o, write_enable_latch, seq, busy, ee, pe, refused, req;
	logic [15:0] prot;
	logic [3:0] susp_blk;
	logic [23:0] paddr;
	logic [7:0] pdata, d;
	logic [8:0] dcnt;
	logic [31:0] exp_q[$];
	int bad_count, n_compared, n_ref;
	sfsp_exit_t tbl[3] = '{'{16'h0020, 1'b0, 24'h04_FFFF}, '{16'h0000, 1'b0, 24'h0F_FFFF},
		'{16'h0000, 1'b1, 24'h06_FFFF}};
	sfsp_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_o(so_h));
	sfsp_flash_seq_prog DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n),
		.si_i(si), .so_i(so_h), .protect_map_i(prot), .suspend_valid_i(susp_v), .suspend_blk_i(susp_blk),
		.prog_fail_i(fail), .so_o(so_o), .so_oe_n_o(so_oe_n_o), .write_enable_latch_o(write_enable_latch), .seq_mode_o(seq),
		.busy_o(busy), .erase_error_flag_o(ee), .program_error_flag_o(pe), .refused_o(refused),
		.prog_req_o(req), .prog_addr_o(paddr), .prog_data_o(pdata), .dual_count_o(dcnt));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// ----------------------------------------
	// Compare and wait helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk({31'h0000_0000, got}, {31'h0000_0000, exp}, what);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		repeat (10) @(negedge clk_i);
		while (busy === 1'b1 && k < 3000) begin
			@(negedge clk_i);
			k++;
		end
		if (k >= 3000) begin
			chk_bit(busy, 1'b0, "busy stuck");
			tally_and_finish();
		end
		repeat (4) @(negedge clk_i);
	endtask
	task automatic seq_go(input logic [7:0] op, input logic [23:0] a, input bit keep);
		d = 8'($urandom);
		if (keep) exp_q.push_back({a, d});
		host.frame({SFSP_OP_WREN, 40'h00_0000_0000}, 8, 1'b0);
		host.frame({op, a, ~d, d}, 48, 1'b0);
		wait_idle();
	endtask
	always @(negedge clk_i) begin
		if (refused === 1'b1) n_ref++;
		if (req === 1'b1) begin
			if (exp_q.size() == 0) chk({paddr, pdata}, 32'hFFFF_FFFF, "unexpected program");
			else chk({paddr, pdata}, exp_q.pop_front(), "program address or data");
		end
	end
	initial begin
		arst_n_i = 1'b0;
		prot = 16'h0000;
		susp_v = 1'b0;
		susp_blk = 4'h7;
		fail = 1'b0;
		bad_count = 0;
		n_compared = 0;
		n_ref = 0;
		void'($urandom(41381));
		repeat (6) @(negedge clk_i);
		arst_n_i = 1'b1;
		repeat (2) @(negedge clk_i);
		seq_go(SFSP_OP_SEQ_A, 24'h01_0000, 1'b1);
		chk_bit(seq, 1'b1, "mode not entered");
		d = 8'($urandom);
		exp_q.push_back({24'h01_0001, d});
		host.frame({SFSP_OP_SEQ_A, ~d, d, 24'h00_0000}, 24, 1'b0);
		wait_idle();
		host.frame({SFSP_OP_WRAP, 40'h00_0000_0000}, 8, 1'b0);
		host.frame({SFSP_OP_PARAM, 40'h00_0000_0000}, 8, 1'b0);
		wait_idle();
		chk(n_ref, 32'h0000_0002, "refusals");
		host.frame({SFSP_OP_SEQ_A, d, 32'h0000_0000}, 13, 1'b0);
		wait_idle();
		chk_bit(write_enable_latch | seq, 1'b0, "abort kept latch or mode");
		prot = 16'h0008;
		seq_go(SFSP_OP_SEQ_B, 24'h03_0010, 1'b0);
		chk_bit(write_enable_latch | seq, 1'b0, "protected start");
		foreach (tbl[i]) begin
			prot = tbl[i].p;
			susp_v = tbl[i].sv;
			seq_go((i % 2 == 1) ? SFSP_OP_SEQ_B : SFSP_OP_SEQ_A, tbl[i].a, 1'b1);
			chk_bit(seq, 1'b0, "mode kept at boundary");
			if (!tbl[i].sv) chk_bit(write_enable_latch, 1'b0, "latch kept at boundary");
		end
		susp_v = 1'b0;
		seq_go(SFSP_OP_SEQ_A, 24'h02_0000, 1'b1);
		host.frame({SFSP_OP_WRDI, 40'h00_0000_0000}, 8, 1'b0);
		wait_idle();
		chk_bit(seq, 1'b0, "mode kept without latch");
		host.frame({SFSP_OP_WREN, 40'h00_0000_0000}, 8, 1'b0);
		d = 8'($urandom);
		exp_q.push_back({24'h00_0100, d});
		host.frame({SFSP_OP_DUAL_PP, 24'h00_0100, ~d, d}, 48, 1'b1);
		wait_idle();
		chk({23'h00_0000, dcnt}, 32'h0000_0002, "dual byte count");
		chk({24'h00_0000, pdata}, {24'h00_0000, d}, "dual data");
		chk_bit(so_oe_n_o & ~so_o, 1'b1, "output pin driven in dual phase");
		fail = 1'b1;
		seq_go(SFSP_OP_SEQ_B, 24'h05_0000, 1'b1);
		chk_bit(pe & ee, 1'b1, "error flags");
		tally_and_finish();
	end
endmodule
